// >>> rtl/wse_engine.sv
// waveform sequence engine: walks the table and streams sample addresses
// assumes trigger and event pins are asynchronous, all else on clk
//
// How it works
// - waveforms need multiple-of-4 length, at least 960
// - summed waveform lengths stay within memory capacity
// - each line plays its repeat total times
// - endless line replays until an event jump
// - endless setting ignored inside a subsequence
// - wait flag holds the line until trigger
// - wait flag only honoured in enhanced mode
// - goto destination taken after line, enhanced only
// - last line always goes back to line 1
// - subsequence lines ignore wait and goto
// - event pin jumps to the line's event target
// - event target is next, a line, or self
// - self target restarts the waveform from start
// - event jumps off for table, software, subsequence
// - subsequences may not call further subsequences
// - missing waveform flags a load error; met while running, it aborts the run
// - table holds at most 8000 lines
`timescale 1ns/1ps
`include "wse_defs.svh"

module wse_engine
  import wse_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tbl_we,
  input wire logic tbl_re,
  input wire logic [`WSE_LINE_W-1:0] tbl_addr,
  input wire logic [`WSE_ENT_W-1:0] tbl_wdata,
  output logic [`WSE_ENT_W-1:0] tbl_rdata,
  input wire logic tbl_clear,
  input wire logic [`WSE_CNT_W-1:0] line_count,
  input wire logic ext_mem,
  input wire wse_run_e run_mode,
  input wire wse_jsrc_e jump_src,
  input wire logic start,
  input wire logic stop,
  input wire logic trig_pin,
  input wire logic event_pin,
  output logic output_channel_one_valid,
  output logic [`WSE_PT_W-1:0] output_channel_one_addr,
  output logic running,
  output logic waiting_trig,
  output logic in_subseq,
  output logic [`WSE_LINE_W-1:0] cur_line,
  output logic load_err,
  output logic run_err
);

  wse_tbl_if tbl();

  wse_table_mem u_mem (
    .clk(clk),
    .tp(tbl.mem)
  );

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] trg_q, trg_d;
  logic [2:0] evt_q, evt_d;
  logic trig_pulse;
  logic ev_pulse;

  // stage 0 feeds only stage 1; edges compare stages 1 and 2
  always_comb begin
    trg_d = {trg_q[1:0], trig_pin};
    evt_d = {evt_q[1:0], event_pin};
    trig_pulse = trg_q[1] & ~trg_q[2];
    ev_pulse = evt_q[1] & ~evt_q[2];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trg_q <= 3'h0;
      evt_q <= 3'h0;
    end else begin
      trg_q <= trg_d;
      evt_q <= evt_d;
    end
  end

  // ----------------------------------------------------------------
  // table loading and checks
  // ----------------------------------------------------------------
  logic [`WSE_SUM_W-1:0] total_q, total_d;
  logic load_err_q, load_err_d;
  logic [`WSE_PT_W-1:0] w_len;
  logic w_sub;
  logic w_bad;
  logic [`WSE_SUM_W-1:0] cap;
  logic [`WSE_CNT_W-1:0] cnt;

  always_comb begin
    w_len = tbl_wdata[`WSE_POS_LEN +: `WSE_PT_W];
    w_sub = tbl_wdata[`WSE_POS_SUB];
    cap = ext_mem ? `WSE_CAP_EXT : `WSE_CAP_STD;
    // count beyond the table size is clamped, not trusted
    cnt = (line_count > `WSE_LINE_MAX) ? `WSE_LINE_MAX : line_count;
    w_bad = 1'b0;
    if (!tbl_wdata[`WSE_POS_PRES]) begin
      w_bad = 1'b1;
    end else if (w_sub) begin
      w_bad = (w_len == `WSE_PT_W'h0);
    end else if (w_len[1:0] != 2'h0 || w_len < `WSE_MIN_PTS) begin
      w_bad = 1'b1;
    end
    // clear starts from zero, but a write in the same cycle still counts and flags
    total_d = tbl_clear ? `WSE_SUM_W'h0 : total_q;
    load_err_d = tbl_clear ? 1'b0 : load_err_q;
    if (tbl_we) begin
      // rewriting a line counts its length again; clear before reloading
      if (!w_sub) begin
        total_d = total_d + {{(`WSE_SUM_W-`WSE_PT_W){1'b0}}, w_len};
      end
      if (w_bad || {1'b0, tbl_addr} >= `WSE_LINE_MAX) begin
        load_err_d = 1'b1;
      end
      if (total_d > cap) begin
        load_err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      total_q <= `WSE_SUM_W'h0;
      load_err_q <= 1'b0;
    end else begin
      total_q <= total_d;
      load_err_q <= load_err_d;
    end
  end

  // writes past the last line are dropped
  assign tbl.a_we = tbl_we && ({1'b0, tbl_addr} < `WSE_LINE_MAX);
  assign tbl.a_re = tbl_re;
  assign tbl.a_addr = tbl_addr;
  assign tbl.a_wdata = tbl_wdata;
  assign tbl_rdata = tbl.a_rdata;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wse_state_e st_q, st_d;
  wse_line_t line_q, line_d;
  wse_line_t sub_q, sub_d;
  wse_line_t sub_end_q, sub_end_d;
  logic in_sub_q, in_sub_d;
  wse_ent_t o_q, o_d;
  wse_ent_t c_q, c_d;
  logic [`WSE_REP_W-1:0] o_rep_q, o_rep_d;
  logic [`WSE_REP_W-1:0] c_rep_q, c_rep_d;
  logic [`WSE_PT_W-1:0] pt_q, pt_d;
  logic run_err_q, run_err_d;
  logic out_v_q, out_v_d;
  logic [`WSE_PT_W-1:0] out_a_q, out_a_d;

  wse_ent_t b_ent;
  logic enh;
  logic last;
  wse_line_t nxt_line;
  wse_line_t adv_line;
  wse_line_t ev_line;
  logic ev_take;
  logic c_inf_eff;
  logic o_inf;
  logic c_more;
  logic o_more;
  logic [`WSE_PT_W-1:0] c_len;
  logic [`WSE_PT_W-1:0] o_start;
  logic [`WSE_PT_W-1:0] o_len;

  // decode of the held lines and the jump targets
  always_comb begin
    b_ent = tbl.b_rdata;
    enh = (run_mode == WSE_RUN_ENH);
    c_len = c_q[`WSE_POS_LEN +: `WSE_PT_W];
    o_start = o_q[`WSE_POS_START +: `WSE_PT_W];
    o_len = o_q[`WSE_POS_LEN +: `WSE_PT_W];
    o_inf = o_q[`WSE_POS_INF];
    c_inf_eff = c_q[`WSE_POS_INF] && !in_sub_q;
    c_more = c_inf_eff || (c_rep_q != c_q[`WSE_POS_REP +: `WSE_REP_W]);
    o_more = o_inf || (o_rep_q != o_q[`WSE_POS_REP +: `WSE_REP_W]);
    last = ({1'b0, line_q} == cnt - `WSE_CNT_W'h1);
    nxt_line = last ? `WSE_LINE_W'h0 : line_q + `WSE_LINE_W'h1;
    if (last) begin
      adv_line = `WSE_LINE_W'h0;
    end else if (enh && o_q[`WSE_POS_GOEN]) begin
      adv_line = o_q[`WSE_POS_GOTO +: `WSE_LINE_W] - `WSE_LINE_W'h1;
    end else begin
      adv_line = nxt_line;
    end
    case (o_q[`WSE_POS_EVM +: 2])
      `WSE_EVM_OFF: ev_line = line_q;
      `WSE_EVM_NEXT: ev_line = nxt_line;
      default: ev_line = o_q[`WSE_POS_EVL +: `WSE_LINE_W] - `WSE_LINE_W'h1;
    endcase
    // jumps only from the event pin source and never inside a subsequence
    ev_take = ev_pulse && (jump_src == WSE_JS_EVENT) && !in_sub_q
              && (st_q == WSE_PLAY || st_q == WSE_WAIT);
  end

  // next state of the sequencer
  always_comb begin
    st_d = st_q;
    line_d = line_q;
    sub_d = sub_q;
    sub_end_d = sub_end_q;
    in_sub_d = in_sub_q;
    o_d = o_q;
    c_d = c_q;
    o_rep_d = o_rep_q;
    c_rep_d = c_rep_q;
    pt_d = pt_q;
    run_err_d = run_err_q;
    out_v_d = 1'b0;
    out_a_d = out_a_q;
    tbl.b_re = 1'b0;
    tbl.b_addr = in_sub_q ? sub_q : line_q;
    case (st_q)
      WSE_IDLE: begin
        // a table that failed its checks is never started
        if (start && !load_err_q && cnt != `WSE_CNT_W'h0) begin
          line_d = `WSE_LINE_W'h0;
          in_sub_d = 1'b0;
          o_rep_d = `WSE_REP_W'h0;
          run_err_d = 1'b0;
          st_d = WSE_FETCH;
        end
      end
      WSE_FETCH: begin
        tbl.b_re = 1'b1;
        st_d = WSE_LOAD;
      end
      WSE_LOAD: begin
        c_rep_d = `WSE_REP_W'h0;
        pt_d = `WSE_PT_W'h0;
        if (!b_ent[`WSE_POS_PRES]) begin
          run_err_d = 1'b1;
          st_d = WSE_IDLE;
        end else if (in_sub_q && b_ent[`WSE_POS_SUB]) begin
          run_err_d = 1'b1;
          st_d = WSE_IDLE;
        end else if (in_sub_q) begin
          c_d = b_ent;
          st_d = WSE_PLAY;
        end else begin
          o_d = b_ent;
          c_d = b_ent;
          if (enh && b_ent[`WSE_POS_WAIT]) begin
            st_d = WSE_WAIT;
          end else begin
            st_d = b_ent[`WSE_POS_SUB] ? WSE_ENTER : WSE_PLAY;
          end
        end
      end
      WSE_WAIT: begin
        if (trig_pulse) begin
          st_d = o_q[`WSE_POS_SUB] ? WSE_ENTER : WSE_PLAY;
        end
      end
      WSE_ENTER: begin
        in_sub_d = 1'b1;
        sub_d = o_start[`WSE_LINE_W-1:0];
        sub_end_d = o_start[`WSE_LINE_W-1:0] + o_len[`WSE_LINE_W-1:0] - `WSE_LINE_W'h1;
        st_d = WSE_FETCH;
      end
      WSE_PLAY: begin
        out_v_d = 1'b1;
        out_a_d = c_q[`WSE_POS_START +: `WSE_PT_W] + pt_q;
        if (pt_q != c_len - `WSE_PT_W'h1) begin
          pt_d = pt_q + `WSE_PT_W'h1;
        end else begin
          pt_d = `WSE_PT_W'h0;
          if (c_more) begin
            // endless lines keep the count still and replay forever
            c_rep_d = c_inf_eff ? c_rep_q : c_rep_q + `WSE_REP_W'h1;
          end else if (in_sub_q && sub_q != sub_end_q) begin
            sub_d = sub_q + `WSE_LINE_W'h1;
            st_d = WSE_FETCH;
          end else if (in_sub_q && o_more) begin
            o_rep_d = o_inf ? o_rep_q : o_rep_q + `WSE_REP_W'h1;
            sub_d = o_start[`WSE_LINE_W-1:0];
            st_d = WSE_FETCH;
          end else begin
            line_d = adv_line;
            in_sub_d = 1'b0;
            o_rep_d = `WSE_REP_W'h0;
            st_d = WSE_FETCH;
          end
        end
      end
      default: st_d = WSE_IDLE;
    endcase
    // event jump; an off target refetches the line and restarts it
    if (ev_take) begin
      line_d = ev_line;
      in_sub_d = 1'b0;
      o_rep_d = `WSE_REP_W'h0;
      out_v_d = 1'b0;
      st_d = WSE_FETCH;
    end
    if (stop) begin
      out_v_d = 1'b0;
      st_d = WSE_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= WSE_IDLE;
      line_q <= `WSE_LINE_W'h0;
      sub_q <= `WSE_LINE_W'h0;
      sub_end_q <= `WSE_LINE_W'h0;
      in_sub_q <= 1'b0;
      o_q <= `WSE_ENT_W'h0;
      c_q <= `WSE_ENT_W'h0;
      o_rep_q <= `WSE_REP_W'h0;
      c_rep_q <= `WSE_REP_W'h0;
      pt_q <= `WSE_PT_W'h0;
      run_err_q <= 1'b0;
      out_v_q <= 1'b0;
      out_a_q <= `WSE_PT_W'h0;
    end else begin
      st_q <= st_d;
      line_q <= line_d;
      sub_q <= sub_d;
      sub_end_q <= sub_end_d;
      in_sub_q <= in_sub_d;
      o_q <= o_d;
      c_q <= c_d;
      o_rep_q <= o_rep_d;
      c_rep_q <= c_rep_d;
      pt_q <= pt_d;
      run_err_q <= run_err_d;
      out_v_q <= out_v_d;
      out_a_q <= out_a_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign output_channel_one_valid = out_v_q;
  assign output_channel_one_addr = out_a_q;
  assign running = (st_q != WSE_IDLE);
  assign waiting_trig = (st_q == WSE_WAIT);
  assign in_subseq = in_sub_q;
  assign cur_line = line_q;
  assign load_err = load_err_q;
  assign run_err = run_err_q;

endmodule

// >>> rtl/wse_defs.svh
// constants of the waveform sequence engine: table layout, limits, counts
// assumes it is included by bare name by the package and the modules
`ifndef WSE_DEFS_SVH
`define WSE_DEFS_SVH

// ----------------------------------------------------------------
// table size and widths
// ----------------------------------------------------------------
`define WSE_LINE_MAX 14'd8000
`define WSE_LINE_W 13
`define WSE_CNT_W 14
`define WSE_PT_W 26
`define WSE_REP_W 16
`define WSE_ENT_W 101
`define WSE_SUM_W 40

// ----------------------------------------------------------------
// field positions inside one table line
// ----------------------------------------------------------------
`define WSE_POS_START 0
`define WSE_POS_LEN 26
`define WSE_POS_SUB 52
`define WSE_POS_PRES 53
`define WSE_POS_REP 54
`define WSE_POS_INF 70
`define WSE_POS_WAIT 71
`define WSE_POS_GOEN 72
`define WSE_POS_GOTO 73
`define WSE_POS_EVM 86
`define WSE_POS_EVL 88

// ----------------------------------------------------------------
// event jump modes and waveform limits
// ----------------------------------------------------------------
`define WSE_EVM_OFF 2'h0
`define WSE_EVM_NEXT 2'h1
`define WSE_EVM_LINE 2'h2
`define WSE_MIN_PTS 26'h00003C0
`define WSE_CAP_STD 40'h0001EE6B80
`define WSE_CAP_EXT 40'h0003DCD700

`endif

// >>> rtl/wse_pkg.sv
// types shared by the waveform sequence engine files
// assumes wse_defs.svh is on the include path
`include "wse_defs.svh"

package wse_pkg;

  typedef logic [`WSE_ENT_W-1:0] wse_ent_t;
  typedef logic [`WSE_LINE_W-1:0] wse_line_t;

  // run modes; only the enhanced one honours wait and goto
  typedef enum logic [1:0] {
    WSE_RUN_CONT,
    WSE_RUN_TRIG,
    WSE_RUN_GATED,
    WSE_RUN_ENH
  } wse_run_e;

  // where jumps come from; only the event pin source is handled here
  typedef enum logic [1:0] {
    WSE_JS_EVENT,
    WSE_JS_TABLE,
    WSE_JS_SOFT
  } wse_jsrc_e;

  typedef enum logic [2:0] {
    WSE_IDLE,
    WSE_FETCH,
    WSE_LOAD,
    WSE_WAIT,
    WSE_ENTER,
    WSE_PLAY
  } wse_state_e;

endpackage

// >>> rtl/wse_tbl_if.sv
// bundle between the engine and its sequence table memory
// assumes one clock; port a serves software, port b the sequencer
`timescale 1ns/1ps

interface wse_tbl_if;
  import wse_pkg::*;
  logic a_we;
  logic a_re;
  wse_line_t a_addr;
  wse_ent_t a_wdata;
  wse_ent_t a_rdata;
  logic b_re;
  wse_line_t b_addr;
  wse_ent_t b_rdata;
  modport mem (input a_we, a_re, a_addr, a_wdata, b_re, b_addr, output a_rdata, b_rdata);
  modport user (output a_we, a_re, a_addr, a_wdata, b_re, b_addr, input a_rdata, b_rdata);
endinterface

// >>> rtl/wse_table_mem.sv
// sequence table storage, two ports, registered read data
// assumes the engine never writes beyond the last line
`timescale 1ns/1ps
`include "wse_defs.svh"

module wse_table_mem
  import wse_pkg::*;
(
  input wire logic clk,
  wse_tbl_if.mem tp
);

  wse_ent_t mem_q [0:`WSE_LINE_MAX-1];
  wse_ent_t a_rd_q;
  wse_ent_t b_rd_q;

  // ----------------------------------------------------------------
  // storage; reads return one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (tp.a_we) begin
      mem_q[tp.a_addr] <= tp.a_wdata;
    end
    if (tp.a_re) begin
      a_rd_q <= mem_q[tp.a_addr];
    end
    if (tp.b_re) begin
      b_rd_q <= mem_q[tp.b_addr];
    end
  end

  assign tp.a_rdata = a_rd_q;
  assign tp.b_rdata = b_rd_q;

endmodule

// >>> sim/wse_engine_sva.sv
// port checker for the sequence engine
// assumes one clock, nrst synchronous active low
`timescale 1ns/1ps
`include "wse_defs.svh"

module wse_engine_sva
  import wse_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tbl_we,
  input wire logic [`WSE_LINE_W-1:0] tbl_addr,
  input wire logic [`WSE_ENT_W-1:0] tbl_wdata,
  input wire logic tbl_clear,
  input wire logic [`WSE_CNT_W-1:0] line_count,
  input wire wse_run_e run_mode,
  input wire logic start,
  input wire logic stop,
  input wire logic trig_pin,
  input wire logic running,
  input wire logic waiting_trig,
  input wire logic in_subseq,
  input wire logic [`WSE_LINE_W-1:0] cur_line,
  input wire logic load_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // legal start request seen while idle
  sequence s_go;
    !running && start && !stop && !load_err && line_count != 14'h0000;
  endsequence
  // trigger edge held long enough to pass the synchroniser
  sequence s_trig;
    waiting_trig && $rose(trig_pin) ##1 trig_pin [*2];
  endsequence
  // a table write whose waveform can never be played
  sequence s_bad_len;
    tbl_we && !tbl_clear && tbl_wdata[52] == 1'h0 &&
      (tbl_wdata[27:26] != 2'h0 || tbl_wdata[51:26] < 26'h00003C0);
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_start_line_one: assert property (s_go |=> running && cur_line == 13'h0000)
    else $error("start did not begin at the first line");
  chk_err_blocks_start: assert property (!running && load_err && start |=> !running)
    else $error("start accepted with a table error");
  chk_stop_idle: assert property (stop |=> !running)
    else $error("stop did not return to idle");
  chk_wait_mode: assert property (waiting_trig |-> run_mode == WSE_RUN_ENH)
    else $error("trigger wait outside enhanced mode");
  chk_wait_nosub: assert property (waiting_trig |-> !in_subseq)
    else $error("trigger wait inside a subsequence");
  chk_trig_release: assert property (s_trig |-> ##[1:5] !waiting_trig)
    else $error("trigger edge did not end the wait");
  chk_addr_limit: assert property (tbl_we && !tbl_clear && tbl_addr >= 13'h1F40 |=> load_err)
    else $error("write beyond the last line not flagged");
  chk_len_shape: assert property (s_bad_len |=> load_err)
    else $error("bad waveform length not flagged");
  chk_absent_line: assert property (tbl_we && !tbl_clear && !tbl_wdata[53] |=> load_err)
    else $error("absent waveform not flagged");
  chk_err_sticky: assert property (load_err && !tbl_clear |=> load_err)
    else $error("table error dropped without clear");
endmodule

bind wse_engine wse_engine_sva u_sva (.clk, .nrst, .tbl_we, .tbl_addr, .tbl_wdata,
  .tbl_clear, .line_count, .run_mode, .start, .stop, .trig_pin, .running,
  .waiting_trig, .in_subseq, .cur_line, .load_err);

// >>> sim/wse_pin_model.sv
// trigger and event sources outside the engine
// assumes pulse is called right after a rising edge
`timescale 1ns/1ps

module wse_pin_model (
  input wire logic clk,
  output logic trig_pin,
  output logic event_pin
);
  // ----------------------------------------
  // pins
  // ----------------------------------------
  initial begin
    trig_pin = 1'h0;
    event_pin = 1'h0;
  end
  // five cycles high: slower than the synchroniser needs, so no edge is lost
  task automatic pulse(input logic ev);
    if (ev) begin
      event_pin <= 1'h1;
    end else begin
      trig_pin <= 1'h1;
    end
    repeat (5) @(posedge clk);
    event_pin <= 1'h0;
    trig_pin <= 1'h0;
  endtask
endmodule

// >>> sim/test_waveform_sequence_engine.sv
// self-checking bench for the sequence engine
// assumes engine, pin model and checker are compiled before it
`timescale 1ns/1ps
`include "wse_defs.svh"

module test_waveform_sequence_engine;
  import wse_pkg::*;
  logic clk = 0, nrst = 0, tbl_we = 0, tbl_re = 0, tbl_clear = 0;
  logic ext_mem = 0, start = 0, stop = 0;
  logic [`WSE_LINE_W-1:0] tbl_addr = '0, cur_line;
  logic [`WSE_ENT_W-1:0] tbl_wdata = '0, tbl_rdata;
  logic [`WSE_CNT_W-1:0] line_count = '0;
  wse_run_e run_mode = WSE_RUN_CONT;
  wse_jsrc_e jump_src = WSE_JS_EVENT;
  logic trig_pin, event_pin, valid, running, waiting_trig, in_subseq, load_err, run_err;
  logic [`WSE_PT_W-1:0] addr;
  int n_mismatch = 0, tests_run = 0, seed = 87428, i, k;
  wse_ent_t w, bad [4];

  always #50 clk = ~clk;

  wse_engine dut (.clk, .nrst, .tbl_we, .tbl_re, .tbl_addr, .tbl_wdata, .tbl_rdata,
    .tbl_clear, .line_count, .ext_mem, .run_mode, .jump_src, .start, .stop, .trig_pin,
    .event_pin, .output_channel_one_valid(valid), .output_channel_one_addr(addr),
    .running, .waiting_trig, .in_subseq, .cur_line, .load_err, .run_err);
  wse_pin_model pm (.clk, .trig_pin, .event_pin);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // present, plain waveform line; r is the repeat total minus one
  function automatic wse_ent_t ln(input logic [25:0] a, len, input logic [15:0] r,
    input logic inf, wt, ge, input logic [12:0] gt, input logic [1:0] em);
    return {13'h0000, em, gt, ge, wt, inf, r, 1'h1, 1'h0, len, a};
  endfunction
  task automatic check(input string nm, input logic [100:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input wse_ent_t d);
    tbl_we <= 1'h1;
    tbl_addr <= a;
    tbl_wdata <= d;
    @(posedge clk);
    tbl_we <= 1'h0;
    @(posedge clk);
  endtask
  task automatic clr;
    tbl_clear <= 1'h1;
    @(posedge clk);
    tbl_clear <= 1'h0;
    @(posedge clk);
  endtask
  task automatic go;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
  endtask
  task automatic halt;
    stop <= 1'h1;
    @(posedge clk);
    stop <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // skip the burst in flight, then capture the next one: first address and length
  task automatic play(input logic [25:0] ea, input int en, input int lim);
    int n, g;
    logic [25:0] a;
    n = 0;
    g = 0;
    @(negedge clk);
    while (valid === 1'h1 && g < lim) begin
      @(negedge clk);
      g++;
    end
    g = 0;
    while (valid !== 1'h1 && g < 200) begin
      @(negedge clk);
      g++;
    end
    a = addr;
    while (valid === 1'h1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("burst start", a, ea);
    if (en > 0) check("burst length", n, en);
    @(posedge clk);
  endtask

  // hang guard, about four times the planned fourteen thousand or so cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    summarize;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    check("running", running, 0);
    check("load_err", load_err, 0);
    $display("test reset done");
    // random words read back as written
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      w = wse_ent_t'({$random(seed), $random(seed), $random(seed), $random(seed)});
      k = {$random(seed)} % 8000;
      wr(k[12:0], w);
      tbl_re <= 1'h1;
      @(posedge clk);
      tbl_re <= 1'h0;
      @(negedge clk);
      check("read data", tbl_rdata, w);
    end
    @(posedge clk);
    $display("test readback done");
    // unusable lines: short, misaligned, absent, beyond the table
    bad[0] = ln(0, 26'h00003BC, 0, 0, 0, 0, 0, 0);
    bad[1] = ln(0, 26'h00003C2, 0, 0, 0, 0, 0, 0);
    bad[2] = ln(0, 26'h00003C0, 0, 0, 0, 0, 0, 0) & ~(101'h1 << 53);
    bad[3] = ln(0, 26'h00003C0, 0, 0, 0, 0, 0, 0);
    line_count <= 14'h0003;
    for (i = 0; i < 4; i++) begin
      clr;
      wr(i == 3 ? 13'h1F40 : 13'h0005, bad[i]);
      @(negedge clk);
      check("load_err", load_err, 1);
      @(posedge clk);
    end
    go;
    repeat (3) @(posedge clk);
    check("running", running, 0);
    // two 20M-point waves exceed the standard memory but fit the extended one
    for (i = 0; i < 2; i++) begin
      ext_mem <= i[0];
      clr;
      wr(1, ln(0, 26'h1312D00, 0, 0, 0, 0, 0, 0));
      wr(2, ln(0, 26'h1312D00, 0, 0, 0, 0, 0, 0));
      @(negedge clk);
      check("capacity", load_err, !i[0]);
      @(posedge clk);
    end
    ext_mem <= 1'h0;
    clr;
    $display("test table errors done");
    // three lines; wait and goto only count in enhanced mode, last goto forced to 1
    wr(0, ln(0, 26'h00003C0, 1, 0, 1, 1, 3, 0));
    wr(1, ln(4096, 26'h00003C4, 0, 0, 0, 0, 0, 0));
    wr(2, ln(8192, 26'h00003C8, 0, 0, 0, 1, 2, 0));
    go;
    play(0, 1920, 4000);
    play(4096, 964, 4000);
    play(8192, 968, 4000);
    play(0, 1920, 4000);
    halt;
    run_mode <= WSE_RUN_ENH;
    go;
    repeat (20) @(posedge clk);
    check("waiting", waiting_trig, 1);
    check("valid", valid, 0);
    // the burst starts before the pulse ends, so watch it while the pin is high
    fork
      pm.pulse(1'h0);
      play(0, 1920, 4000);
    join
    play(8192, 968, 4000);
    repeat (20) @(posedge clk);
    check("wrap line", cur_line, 0);
    check("waiting", waiting_trig, 1);
    halt;
    $display("test run modes done");
    // endless lines left only by events; off restarts the same line
    run_mode <= WSE_RUN_CONT;
    line_count <= 14'h0002;
    wr(0, ln(0, 26'h00003C0, 0, 1, 0, 0, 0, 1));
    wr(1, ln(4096, 26'h00003C4, 0, 1, 0, 0, 0, 0));
    go;
    play(0, 0, 1500);
    check("endless line", cur_line, 0);
    pm.pulse(1'h1);
    play(4096, 0, 100);
    pm.pulse(1'h1);
    play(4096, 0, 100);
    jump_src <= WSE_JS_TABLE;
    pm.pulse(1'h1);
    k = 0;
    repeat (60) begin
      @(negedge clk);
      if (valid === 1'h1) k++;
    end
    check("ignored event", k, 60);
    halt;
    $display("test events done");
    // subsequence on lines 3 and 4: endless and wait flags there are ignored
    run_mode <= WSE_RUN_ENH;
    wr(0, ln(2, 2, 0, 0, 0, 0, 0, 0) | (101'h1 << 52));
    wr(1, ln(4096, 26'h00003C4, 0, 0, 0, 0, 0, 0));
    wr(2, ln(8192, 26'h00003C0, 0, 1, 1, 0, 0, 0));
    wr(3, ln(12288, 26'h00003C4, 0, 0, 0, 0, 0, 0));
    go;
    play(8192, 960, 4000);
    check("in subsequence", in_subseq, 1);
    play(12288, 964, 4000);
    play(4096, 964, 4000);
    check("in subsequence", in_subseq, 0);
    halt;
    // a subsequence line that calls another subsequence aborts the run
    wr(2, ln(2, 2, 0, 0, 0, 0, 0, 0) | (101'h1 << 52));
    go;
    repeat (10) @(posedge clk);
    check("nested run error", run_err, 1);
    check("running", running, 0);
    halt;
    $display("test subsequences done");
    summarize;
  end
endmodule
